/* File: src/dpsc_nv_mem.sv */
// Wiper nonvolatile memory array, one write and one registered read port.
// Assumes the caller never writes past the last of the DEPTH locations.
`timescale 1ns/1ps

module dpsc_nv_mem #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 20,
	parameter int AW    = 5
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic [AW-1:0]    i_raddr,
	output logic      [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// ==========================================================
	// Array write; no reset so it maps onto plain storage
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Registered read, one cycle of latency
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule

/* File: src/dpsc_pkg.sv */
// Constants, types and encodings shared by the serial control port.
// Assumes one 40 MHz system clock; all pins arrive asynchronous to it.

package dpsc_pkg;

	// ==========================================================
	// Frame geometry
	localparam int FRAME_BITS = 16;
	localparam int CNT_W      = 4;
	localparam int CMD_W      = 4;
	localparam int DATA_W     = 10;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;

	// ==========================================================
	// Wiper and nonvolatile memory
	localparam logic [DATA_W-1:0] WIPER_MIDSCALE = 10'h200;
	localparam logic [DATA_W-1:0] WIPER_ZERO_B   = 10'h000;
	localparam logic [DATA_W-1:0] LOW_RES_MASK   = 10'h3fc;
	localparam int NV_DEPTH = 20;
	localparam int NV_AW    = 5;
	localparam logic [NV_AW-1:0] NV_COUNT_FULL = 5'h14;

	// ==========================================================
	// Timing
	localparam int CLK_FREQ_MHZ  = 40;
	localparam int STORE_TIME_US = 6000;
	localparam int STORE_CYCLES  = STORE_TIME_US * CLK_FREQ_MHZ;

	// ==========================================================
	// Commands and states
	typedef enum logic [CMD_W-1:0] {
		CMD_NOP      = 4'h0,
		CMD_WRITE    = 4'h1,
		CMD_READBACK = 4'h2,
		CMD_STORE    = 4'h3,
		CMD_REFRESH  = 4'h4
	} dpsc_cmd_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STORE = 2'b01,
		ST_FETCH = 2'b10,
		ST_LOAD  = 2'b11
	} dpsc_state_e;

	typedef struct packed {
		logic [1:0]        zeros;
		logic [CMD_W-1:0]  cmd;
		logic [DATA_W-1:0] data;
	} dpsc_frame_s;

	typedef struct packed {
		logic sync_n;
		logic sclk;
		logic din;
		logic hw_reset;
	} dpsc_pins_s;

endpackage

/* File: src/dpsc_serial_port.sv */
// Serial control port of a single-channel digital potentiometer.
// Assumes frame-sync, serial clock, data and reset pins are asynchronous
// and slow enough (serial clock period >= 8 system clocks) to oversample.
`timescale 1ns/1ps

module dpsc_serial_port #(
	parameter int STORE_CYCLES = dpsc_pkg::STORE_CYCLES,
	parameter bit LOW_RES      = 1'b0
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst,
	input  wire logic                        i_sync_n,
	input  wire logic                        i_sclk,
	input  wire logic                        i_din,
	input  wire logic                        i_hw_reset,
	output logic      [dpsc_pkg::DATA_W-1:0] o_wiper,
	output logic                             o_sdo_o,
	output logic                             o_sdo_oe,
	output logic                             o_rdy_o,
	output logic                             o_rdy_oe,
	output logic      [dpsc_pkg::NV_AW-1:0]  o_nv_count
);

	localparam int TMR_W = $clog2(STORE_CYCLES + 1);
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(STORE_CYCLES - 1);

	// ==========================================================
	// Pin synchronisers
	dpsc_pkg::dpsc_pins_s pins_in;
	dpsc_pkg::dpsc_pins_s pins_meta;
	dpsc_pkg::dpsc_pins_s pins_sync;
	dpsc_pkg::dpsc_pins_s pins_prev;

	assign pins_in = '{sync_n: i_sync_n, sclk: i_sclk, din: i_din,
		hw_reset: i_hw_reset};

	// Idle levels: sync high, clock high, reset pin high (tied when unused)
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pins_meta <= 4'hd;
			pins_sync <= 4'hd;
			pins_prev <= 4'hd;
		end else begin
			pins_meta <= pins_in;
			pins_sync <= pins_meta;
			pins_prev <= pins_sync;
		end
	end

	// ==========================================================
	// Edge detection on synchronised pins only
	logic sclk_fall;
	logic sync_rise;
	logic hw_rise;

	assign sclk_fall = pins_prev.sclk & ~pins_sync.sclk;
	assign sync_rise = ~pins_prev.sync_n & pins_sync.sync_n;
	assign hw_rise   = ~pins_prev.hw_reset & pins_sync.hw_reset;

	// ==========================================================
	// State and storage
	dpsc_pkg::dpsc_state_e                 state;
	dpsc_pkg::dpsc_state_e                 next_state;
	logic [dpsc_pkg::FRAME_BITS-1:0]       sreg;
	logic [dpsc_pkg::FRAME_BITS-1:0]       next_sreg;
	logic [dpsc_pkg::CNT_W-1:0]            bit_cnt;
	logic                                  seen16;
	logic [TMR_W-1:0]                      tmr;
	logic                                  por_pend;
	logic [dpsc_pkg::DATA_W-1:0]           wiper;
	logic [dpsc_pkg::DATA_W-1:0]           next_wiper;
	logic [dpsc_pkg::NV_AW-1:0]            nv_count;
	logic [dpsc_pkg::DATA_W-1:0]           nv_rdata;

	// ==========================================================
	// Frame decode
	dpsc_pkg::dpsc_frame_s frame;
	logic [dpsc_pkg::DATA_W-1:0] frame_data;
	logic locked;
	logic shift_en;
	logic frame_ok;
	logic nv_empty;
	logic nv_full;
	logic do_write;
	logic do_readback;
	logic do_store;
	logic do_refresh;
	logic store_done;

	assign frame      = dpsc_pkg::dpsc_frame_s'(sreg);
	// Low-resolution build ignores the two lowest data bits
	assign frame_data = LOW_RES ? (frame.data & dpsc_pkg::LOW_RES_MASK)
		: frame.data;
	assign locked     = (state != dpsc_pkg::ST_IDLE);
	assign shift_en   = ~pins_sync.sync_n & sclk_fall & ~locked;
	// Whole multiples of sixteen only; anything else is an abort
	assign frame_ok   = sync_rise & seen16 & (bit_cnt == '0)
		& ~locked;
	assign nv_empty   = (nv_count == '0);
	assign nv_full    = (nv_count == dpsc_pkg::NV_COUNT_FULL);
	assign do_write    = frame_ok & (frame.cmd == dpsc_pkg::CMD_WRITE);
	assign do_readback = frame_ok & (frame.cmd == dpsc_pkg::CMD_READBACK);
	assign do_store    = frame_ok & (frame.cmd == dpsc_pkg::CMD_STORE)
		& ~nv_full;
	assign do_refresh  = (frame_ok & (frame.cmd == dpsc_pkg::CMD_REFRESH))
		| hw_rise | por_pend;
	assign store_done  = (state == dpsc_pkg::ST_STORE) & (tmr == TMR_LAST);

	// ==========================================================
	// Next state, wiper and shift register
	always_comb begin
		next_state = state;
		next_wiper = wiper;
		next_sreg  = sreg;
		if (shift_en) begin
			next_sreg = {sreg[dpsc_pkg::FRAME_BITS-2:0],
				pins_sync.din};
		end else if (do_readback) begin
			next_sreg = {2'b00, dpsc_pkg::CMD_READBACK, wiper};
		end
		case (state)
			dpsc_pkg::ST_IDLE: begin
				if (do_write) begin
					next_wiper = frame_data;
				end else if (do_store) begin
					next_state = dpsc_pkg::ST_STORE;
				end else if (do_refresh && nv_empty) begin
					next_wiper = dpsc_pkg::WIPER_MIDSCALE;
				end else if (do_refresh) begin
					next_state = dpsc_pkg::ST_FETCH;
				end
			end
			dpsc_pkg::ST_STORE: begin
				if (store_done) begin
					next_state = dpsc_pkg::ST_IDLE;
				end
			end
			dpsc_pkg::ST_FETCH: begin
				next_state = dpsc_pkg::ST_LOAD;
			end
			dpsc_pkg::ST_LOAD: begin
				next_wiper = nv_rdata;
				next_state = dpsc_pkg::ST_IDLE;
			end
			default: begin
				next_state = dpsc_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state    <= dpsc_pkg::ST_IDLE;
			wiper    <= dpsc_pkg::WIPER_MIDSCALE;
			sreg     <= '0;
			por_pend <= 1'b1;
		end else begin
			state    <= next_state;
			wiper    <= next_wiper;
			sreg     <= next_sreg;
			por_pend <= por_pend & locked; // Power-on refresh once idle
		end
	end

	// Bit counter; wraps every sixteen clocks, cleared at frame start
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bit_cnt <= '0;
			seen16  <= 1'b0;
		end else if (pins_sync.sync_n) begin
			bit_cnt <= '0;
			seen16  <= 1'b0;
		end else if (shift_en) begin
			bit_cnt <= bit_cnt + 4'h1;
			seen16  <= seen16 | (bit_cnt == dpsc_pkg::CNT_LAST);
		end
	end

	// Store timer and programmed-location count
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tmr      <= '0;
			nv_count <= '0;
		end else begin
			tmr      <= (state == dpsc_pkg::ST_STORE) ? tmr + 1'b1 : '0;
			if (store_done) begin
				nv_count <= nv_count + 5'h01;
			end
		end
	end

	// ==========================================================
	// Wiper memory; write at store entry, read newest location
	logic [dpsc_pkg::NV_AW-1:0] nv_raddr;

	assign nv_raddr = nv_empty ? '0 : nv_count - 5'h01;

	dpsc_nv_mem #(
		.WIDTH (dpsc_pkg::DATA_W),
		.DEPTH (dpsc_pkg::NV_DEPTH),
		.AW    (dpsc_pkg::NV_AW)
	) u_nv_mem (
		.i_clk   (i_mclk),
		.i_rst   (i_rst),
		.i_we    (do_store & ~locked),
		.i_waddr (nv_count),
		.i_wdata (wiper),
		.i_raddr (nv_raddr),
		.o_rdata (nv_rdata)
	);

	// ==========================================================
	// Pin outputs; open drain pulls low only, so data level is always 0
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_wiper    <= dpsc_pkg::WIPER_MIDSCALE;
			o_sdo_o    <= 1'b0;
			o_sdo_oe   <= 1'b0;
			o_rdy_o    <= 1'b0;
			o_rdy_oe   <= 1'b1;
			o_nv_count <= '0;
		end else begin
			o_wiper    <= next_wiper;
			o_sdo_o    <= 1'b0;
			// Released outside frames so chained parts share the line
			o_sdo_oe   <= ~pins_sync.sync_n
				& ~next_sreg[dpsc_pkg::FRAME_BITS-1];
			o_rdy_o    <= 1'b0;
			// Held low while busy; released high on completion
			o_rdy_oe   <= (next_state != dpsc_pkg::ST_IDLE)
				| por_pend;
			o_nv_count <= nv_count + (store_done ? 5'h01 : 5'h00);
		end
	end

endmodule

/* File: tb/dpsc_host_model.sv */
// Host-side serial master for the potentiometer control port.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps

module dpsc_host (
	output logic      o_sync_n,
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_sdo,
	input  wire logic i_rdy
);
	// ==========================================================
	// Frame engine; clock idles high and stands still between frames
	logic [15:0] rx;

	initial begin
		o_sync_n = 1'b1;
		o_sclk   = 1'b1;
		o_din    = 1'b0;
		rx       = 16'h0000;
	end

	// Bit is set while clock is high, so it is stable at the fall
	task automatic xfer(input logic [31:0] w, input int n, input bit wt);
		int k;
		k = 0;
		while (wt && !i_rdy && k < 4000) begin
			#25 k++;
		end
		o_sync_n = 1'b0;
		#100;
		for (int i = n - 1; i >= 0; i--) begin
			o_din = w[i];
			#100 rx = {rx[14:0], i_sdo};
			o_sclk = 1'b0;
			#100 o_sclk = 1'b1;
		end
		#100 o_sync_n = 1'b1;
		o_din = ~o_din; // Released: show a changed level
		#200;
	endtask
endmodule

/* File: tb/dpsc_serial_port_chk.sv */
// Concurrent checks on the serial control port's top-level pins.
// Assumes pull-ups on both open-drain outputs outside the block.
`timescale 1ns/1ps

module dpsc_serial_port_chk #(
	parameter int STORE_CYCLES = dpsc_pkg::STORE_CYCLES,
	parameter bit LOW_RES      = 1'b0
) (
	input wire logic                        i_mclk,
	input wire logic                        i_rst,
	input wire logic                        i_sync_n,
	input wire logic                        i_sclk,
	input wire logic                        i_din,
	input wire logic                        i_hw_reset,
	input wire logic [dpsc_pkg::DATA_W-1:0] o_wiper,
	input wire logic                        o_sdo_o,
	input wire logic                        o_sdo_oe,
	input wire logic                        o_rdy_o,
	input wire logic                        o_rdy_oe,
	input wire logic [dpsc_pkg::NV_AW-1:0]  o_nv_count
);
	// ==========================================================
	// Length of the latest busy run, held after ready returns
	int   run;
	logic rdy_q;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			run   <= 0;
			rdy_q <= 1'b1;
		end else begin
			rdy_q <= o_rdy_oe;
			run   <= (o_rdy_oe && !rdy_q) ? 1 : run + int'(o_rdy_oe);
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	// Only a store keeps ready low this long
	sequence busy_run;
		o_rdy_oe [*5];
	endsequence

	od_sdo_a: assert property (o_sdo_oe |-> !o_sdo_o)
		else $error("serial out driven high");
	od_rdy_a: assert property (o_rdy_oe |-> !o_rdy_o)
		else $error("ready driven high");
	sdo_idle_a: assert property (i_sync_n [*6] |-> !o_sdo_oe)
		else $error("serial out pulled outside a frame");
	wiper_sync_a: assert property ($changed(o_wiper) |->
		i_sync_n && $past(i_sync_n, 3))
		else $error("wiper changed inside a frame");
	nv_step_a: assert property ($changed(o_nv_count) |->
		o_nv_count == $past(o_nv_count) + 5'h01)
		else $error("nv count jumped");
	nv_limit_a: assert property (o_nv_count <= dpsc_pkg::NV_COUNT_FULL)
		else $error("nv count beyond twenty");
	store_lock_a: assert property (busy_run |-> $stable(o_wiper))
		else $error("wiper moved during store");
	store_time_a: assert property ($changed(o_nv_count) |->
		run >= STORE_CYCLES - 1 && run <= STORE_CYCLES + 4)
		else $error("store busy time wrong");
	rdy_release_a: assert property ($fell(i_rst) |->
		##[0:8] !o_rdy_oe)
		else $error("ready not released after reset");
endmodule

bind dpsc_serial_port dpsc_serial_port_chk #(
	.STORE_CYCLES(STORE_CYCLES),
	.LOW_RES(LOW_RES)
) chk_i (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_sync_n(i_sync_n),
	.i_sclk(i_sclk), .i_din(i_din), .i_hw_reset(i_hw_reset),
	.o_wiper(o_wiper), .o_sdo_o(o_sdo_o), .o_sdo_oe(o_sdo_oe),
	.o_rdy_o(o_rdy_o), .o_rdy_oe(o_rdy_oe), .o_nv_count(o_nv_count)
);

/* File: tb/tb_dpsc_serial_port.sv */
// Self-checking bench for the serial control port with a host model.
// Assumes a short store time so the whole run stays brief.
`timescale 1ns/1ps

module tb_dpsc_serial_port;
	// ==========================================================
	// Clock, reset, pins and the pulled-up open-drain wires
	logic       i_mclk;
	logic       i_rst;
	logic       i_hw_reset;
	wire logic  sync_n, sclk, din;
	logic [9:0] wiper;
	logic [9:0] wiper_lr;
	logic [4:0] nv_count;
	logic       sdo_o, sdo_oe, rdy_o, rdy_oe;
	wire logic  sdo_w = !sdo_oe;
	wire logic  rdy_w = !rdy_oe;
	int         fail_count = 0;
	int         comparisons = 0;
	int         cyc = 0;
	// Store must outlast a whole frame so the lock can be seen
	localparam int STORE_SIM = 400;

	dpsc_serial_port #(.STORE_CYCLES(STORE_SIM), .LOW_RES(1'b0)) dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_sync_n(sync_n),
		.i_sclk(sclk), .i_din(din), .i_hw_reset(i_hw_reset),
		.o_wiper(wiper), .o_sdo_o(sdo_o), .o_sdo_oe(sdo_oe),
		.o_rdy_o(rdy_o), .o_rdy_oe(rdy_oe), .o_nv_count(nv_count));
	dpsc_host host (.o_sync_n(sync_n), .o_sclk(sclk), .o_din(din),
		.i_sdo(sdo_w), .i_rdy(rdy_w));

	// Low-resolution build on the same pins; the bench reads only its wiper, the bound checks cover all its outputs
	dpsc_serial_port #(.STORE_CYCLES(STORE_SIM), .LOW_RES(1'b1)) dut_lr (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_sync_n(sync_n),
		.i_sclk(sclk), .i_din(din), .i_hw_reset(i_hw_reset),
		.o_wiper(wiper_lr), .o_sdo_o(), .o_sdo_oe(), .o_rdy_o(),
		.o_rdy_oe(), .o_nv_count());

	always #12.5 i_mclk = ~i_mclk;

	// Hang guard; a full run needs well under half of this
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] fw(input logic [3:0] c,
		input logic [9:0] d);
		return {16'h0000, 2'b00, c, d};
	endfunction

	// Pins move just after an edge so samplers never race the host
	task automatic send(input logic [31:0] w, input int n, input bit wt);
		@(posedge i_mclk);
		#2 host.xfer(w, n, wt);
		if (wt) repeat (8) @(posedge i_mclk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk({6'h00, wiper}, {6'h00, dpsc_pkg::WIPER_MIDSCALE});
		chk({11'h000, nv_count}, 16'h0000);
		chk({15'h0000, rdy_w}, 16'h0001);
		$display("test reset done");
	endtask

	task automatic t_write();
		send(fw(dpsc_pkg::CMD_WRITE, 10'h155), 16, 1'b1);
		chk({6'h00, wiper}, 16'h0155);
		chk({6'h00, wiper_lr}, 16'h0154);
		send(fw(dpsc_pkg::CMD_WRITE, 10'h000), 16, 1'b1);
		chk({6'h00, wiper}, {6'h00, dpsc_pkg::WIPER_ZERO_B});
		$display("test write done");
	endtask

	task automatic t_abort();
		send(fw(dpsc_pkg::CMD_WRITE, 10'h3ff), 15, 1'b1);
		chk({6'h00, wiper}, 16'h0000);
		send(fw(dpsc_pkg::CMD_WRITE, 10'h3ff), 17, 1'b1);
		chk({6'h00, wiper}, 16'h0000);
		send(32'h0fff0000 | fw(dpsc_pkg::CMD_WRITE, 10'h0aa), 32, 1'b1);
		chk({6'h00, wiper}, 16'h00aa);
		send(fw(dpsc_pkg::CMD_REFRESH, 10'h000), 16, 1'b1);
		chk({6'h00, wiper}, {6'h00, dpsc_pkg::WIPER_MIDSCALE});
		$display("test abort done");
	endtask

	task automatic t_store();
		send(fw(dpsc_pkg::CMD_WRITE, 10'h123), 16, 1'b1);
		send(fw(dpsc_pkg::CMD_STORE, 10'h000), 16, 1'b0);
		// Whole frame falls inside the store lock
		send(fw(dpsc_pkg::CMD_WRITE, 10'h3ff), 16, 1'b0);
		chk({6'h00, wiper}, 16'h0123);
		chk({15'h0000, rdy_w}, 16'h0000);
		send(fw(dpsc_pkg::CMD_WRITE, 10'h0f0), 16, 1'b1);
		chk({11'h000, nv_count}, 16'h0001);
		chk({6'h00, wiper}, 16'h00f0);
		@(posedge i_mclk);
		#2 i_hw_reset = 1'b0;
		repeat (8) @(posedge i_mclk);
		chk({6'h00, wiper}, 16'h00f0);
		#2 i_hw_reset = 1'b1;
		repeat (12) @(posedge i_mclk);
		chk({6'h00, wiper}, 16'h0123);
		send(fw(dpsc_pkg::CMD_WRITE, 10'h0f0), 16, 1'b1);
		repeat (20) @(posedge i_mclk);
		chk({6'h00, wiper}, 16'h00f0);
		$display("test store done");
	endtask

	task automatic t_readback();
		send(fw(dpsc_pkg::CMD_READBACK, 10'h000), 16, 1'b1);
		send(fw(dpsc_pkg::CMD_NOP, 10'h000), 16, 1'b1);
		chk(host.rx, {2'b00, dpsc_pkg::CMD_READBACK, 10'h0f0});
		$display("test readback done");
	endtask

	initial begin
		i_mclk = 1'b0;
		i_rst = 1'b1;
		i_hw_reset = 1'b1;
		repeat (2) @(posedge i_mclk);
		#2 i_rst = 1'b0;
		repeat (8) @(posedge i_mclk);
		t_reset();
		t_write();
		t_abort();
		t_store();
		t_readback();
		print_verdict();
	end
endmodule
